// *** rmb_slave.sv ***
// RTU slave front end: frame capture, decode, register access strobes, reply.
// Assumes the drive logic shares clk and answers rd_addr in the same cycle.
//
// Operation
// - Station address 1..31 is held and used to recognise own requests.
// - Selector 0 none, 1 vendor protocol, 2 RTU; only the matching handler runs.
// - Baud codes 5..13 map to 4800 through 187500 baud.
// - Address 1..31 is unicast, handled only on station match.
// - Address 0 is broadcast, accepted by every slave.
// - Broadcast requests never get a reply; master never expects one.
// - Only binary RTU framing is accepted; ASCII frames are not recognised.
// - Exactly three functions: read registers, write one, write several.
// - Any other function gets an error response unless broadcast, and nothing is executed.
// - Read request is eight bytes: address, function, start, count, CRC.
// - Single write is eight bytes: address, function, register, value, CRC.
// - Multiple write carries start, count, byte count, N value bytes, CRC.
// - Reads only through function 3, writes only through functions 6 or 16.
// - After reset the selector defaults to the vendor protocol.
`timescale 1ns/1ps
`default_nettype none
module rmb_slave (
  input wire logic clk,
  input wire logic rst,
  input wire logic cfg_load,
  input wire logic [4:0] bus_station_address_setting,
  input wire logic [1:0] link_protocol_selector,
  input wire logic [3:0] link_baud_code,
  input wire logic rx_pin,
  input wire logic [15:0] rd_data,
  output logic tx_pin,
  output logic tx_en,
  output logic modbus_en,
  output logic vendor_en,
  output logic wr_valid,
  output logic [15:0] wr_addr,
  output logic [15:0] wr_data,
  output logic wr_broadcast,
  output logic [15:0] rd_addr
);
  typedef enum logic [7:0] {
    ST_WAIT_GAP = 8'h01,
    ST_IDLE = 8'h02,
    ST_RX = 8'h04,
    ST_CHECK = 8'h08,
    ST_WRITE = 8'h10,
    ST_READ = 8'h20,
    ST_TX_WAIT = 8'h40,
    ST_TX = 8'h80
  } rmb_state_e;

  typedef struct packed {
    rmb_state_e state;
    logic [4:0] station;
    logic [1:0] proto;
    logic [15:0] bit_clocks;
    logic [rmb_pkg::BUF_BYTES-1:0][7:0] frame;
    logic [6:0] len;
    logic [15:0] crc;
    logic bcast;
    logic [6:0] txlen;
    logic [6:0] idx;
    logic phase;
    logic [15:0] start;
    logic [4:0] ri;
    logic [4:0] rcount;
    logic tx_start;
    logic [7:0] tx_byte;
    logic tx_en;
    logic modbus_en;
    logic vendor_en;
    logic wr_valid;
    logic [15:0] wr_addr;
    logic [15:0] wr_data;
    logic [15:0] rd_addr;
  } rmb_slave_s;

  localparam rmb_slave_s SLAVE_RST = '{
    state: ST_WAIT_GAP,
    station: rmb_pkg::STATION_RST,
    proto: rmb_pkg::PROTO_RST,
    bit_clocks: rmb_pkg::bit_clock_count(rmb_pkg::BAUD_RST),
    crc: rmb_pkg::CRC_INIT,
    vendor_en: 1'b1,
    default: '0
  };

  rmb_slave_s r;
  rmb_slave_s next_r;
  logic rx_valid;
  logic [7:0] rx_byte;
  logic rx_error;
  logic line_quiet;
  logic tx_busy;

  rmb_uart u_uart (
    .clk(clk),
    .rst(rst),
    .bit_clocks(r.bit_clocks),
    .rx_pin(rx_pin),
    .tx_start(r.tx_start),
    .tx_byte(r.tx_byte),
    .rx_valid(rx_valid),
    .rx_byte(rx_byte),
    .rx_error(rx_error),
    .line_quiet(line_quiet),
    .tx_busy(tx_busy),
    .tx_pin(tx_pin)
  );

  always_comb begin
    logic [7:0] fc;
    logic [15:0] cnt;
    logic [7:0] out_byte;
    logic last;
    next_r = r;
    fc = r.frame[1];
    cnt = {r.frame[4], r.frame[5]};
    out_byte = 8'h00;
    last = (5'(r.ri + 5'h01) == r.rcount);
    next_r.tx_start = 1'b0;
    next_r.wr_valid = 1'b0;
    // Configuration load, out-of-range station address or baud code keeps the old setting; any selector value is taken
    if (cfg_load) begin
      if (bus_station_address_setting >= rmb_pkg::STATION_MIN &&
          bus_station_address_setting <= rmb_pkg::STATION_MAX) begin
        next_r.station = bus_station_address_setting;
      end
      next_r.proto = link_protocol_selector;
      if (rmb_pkg::bit_clock_count(link_baud_code) != 16'h0000) begin
        next_r.bit_clocks = rmb_pkg::bit_clock_count(link_baud_code);
      end
    end
    next_r.modbus_en = (next_r.proto == rmb_pkg::PROTO_MODBUS);
    next_r.vendor_en = (next_r.proto == rmb_pkg::PROTO_VENDOR);
    unique case (r.state)
      ST_WAIT_GAP: begin
        if (line_quiet) begin
          next_r.state = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (rx_valid && r.modbus_en) begin
          next_r.frame[0] = rx_byte;
          next_r.len = 7'h01;
          next_r.crc = rmb_pkg::crc16_byte(rmb_pkg::CRC_INIT, rx_byte);
          next_r.state = rx_error ? ST_WAIT_GAP : ST_RX;
        end
      end
      ST_RX: begin
        if (rx_valid) begin
          if (rx_error || r.len == rmb_pkg::LEN_FULL) begin
            next_r.state = ST_WAIT_GAP;
          end else begin
            next_r.frame[r.len[5:0]] = rx_byte;
            next_r.len = r.len + 7'h01;
            next_r.crc = rmb_pkg::crc16_byte(r.crc, rx_byte);
          end
        end else if (line_quiet) begin
          next_r.state = ST_CHECK;
        end
      end
      ST_CHECK: begin
        next_r.state = ST_IDLE;
        next_r.bcast = (r.frame[0] == rmb_pkg::ADDR_BROADCAST);
        next_r.start = {r.frame[2], r.frame[3]};
        next_r.ri = 5'h00;
        next_r.phase = 1'b0;
        // Bad CRC or foreign station: dropped without a word
        if (r.crc == 16'h0000 && r.len >= rmb_pkg::LEN_MIN &&
            (r.frame[0] == rmb_pkg::ADDR_BROADCAST || r.frame[0] == {3'h0, r.station})) begin
          case (fc)
            rmb_pkg::FC_READ: begin
              if (r.len == rmb_pkg::LEN_FIXED && !next_r.bcast) begin
                if (cnt != 16'h0000 && cnt <= rmb_pkg::MAX_REGS) begin
                  next_r.rcount = cnt[4:0];
                  next_r.frame[2] = {2'h0, cnt[4:0], 1'b0};
                  next_r.idx = rmb_pkg::READ_HDR;
                  next_r.txlen = 7'(rmb_pkg::READ_HDR + {1'b0, cnt[4:0], 1'b0});
                  next_r.state = ST_READ;
                end else begin
                  next_r.frame[1] = fc | rmb_pkg::EXC_FLAG;
                  next_r.frame[2] = rmb_pkg::EXC_ILL_VALUE;
                  next_r.txlen = rmb_pkg::EXC_LEN;
                  next_r.state = ST_TX_WAIT;
                end
              end
            end
            rmb_pkg::FC_WRITE1: begin
              if (r.len == rmb_pkg::LEN_FIXED) begin
                next_r.rcount = 5'h01;
                next_r.idx = rmb_pkg::WRITE1_DATA;
                next_r.txlen = rmb_pkg::ECHO_LEN;
                next_r.state = ST_WRITE;
              end
            end
            rmb_pkg::FC_WRITEN: begin
              if ({2'h0, r.len} == 9'(rmb_pkg::LEN_MULTI_BASE + {1'b0, r.frame[6]})) begin
                if (cnt != 16'h0000 && cnt <= rmb_pkg::MAX_REGS && r.frame[6] == {2'h0, cnt[4:0], 1'b0}) begin
                  next_r.rcount = cnt[4:0];
                  next_r.idx = rmb_pkg::WRITEN_DATA;
                  next_r.txlen = rmb_pkg::ECHO_LEN;
                  next_r.state = ST_WRITE;
                end else if (!next_r.bcast) begin
                  next_r.frame[1] = fc | rmb_pkg::EXC_FLAG;
                  next_r.frame[2] = rmb_pkg::EXC_ILL_VALUE;
                  next_r.txlen = rmb_pkg::EXC_LEN;
                  next_r.state = ST_TX_WAIT;
                end
              end
            end
            default: begin
              if (!next_r.bcast) begin
                next_r.frame[1] = fc | rmb_pkg::EXC_FLAG;
                next_r.frame[2] = rmb_pkg::EXC_ILL_FUNC;
                next_r.txlen = rmb_pkg::EXC_LEN;
                next_r.state = ST_TX_WAIT;
              end
            end
          endcase
        end
      end
      ST_WRITE: begin
        next_r.wr_valid = 1'b1;
        next_r.wr_addr = r.start + {11'h000, r.ri};
        next_r.wr_data = {r.frame[r.idx[5:0]], r.frame[6'(r.idx[5:0] + 6'h01)]};
        next_r.idx = r.idx + 7'h02;
        next_r.ri = r.ri + 5'h01;
        if (last) begin
          next_r.state = r.bcast ? ST_IDLE : ST_TX_WAIT;
        end
      end
      ST_READ: begin
        if (!r.phase) begin
          next_r.rd_addr = r.start + {11'h000, r.ri};
          next_r.phase = 1'b1;
        end else begin
          next_r.frame[r.idx[5:0]] = rd_data[15:8];
          next_r.frame[6'(r.idx[5:0] + 6'h01)] = rd_data[7:0];
          next_r.idx = r.idx + 7'h02;
          next_r.ri = r.ri + 5'h01;
          next_r.phase = 1'b0;
          if (last) begin
            next_r.state = ST_TX_WAIT;
          end
        end
      end
      ST_TX_WAIT: begin
        next_r.idx = 7'h00;
        next_r.phase = 1'b0;
        next_r.crc = rmb_pkg::CRC_INIT;
        if (line_quiet) begin
          next_r.tx_en = 1'b1;
          next_r.state = ST_TX;
        end
      end
      ST_TX: begin
        if (r.phase) begin
          next_r.phase = !tx_busy;
        end else if (!tx_busy) begin
          if (r.idx == 7'(r.txlen + 7'h02)) begin
            next_r.tx_en = 1'b0;
            next_r.state = ST_IDLE;
          end else begin
            if (r.idx < r.txlen) begin
              out_byte = r.frame[r.idx[5:0]];
              next_r.crc = rmb_pkg::crc16_byte(r.crc, out_byte);
            end else if (r.idx == r.txlen) begin
              out_byte = r.crc[7:0];
            end else begin
              out_byte = r.crc[15:8];
            end
            next_r.tx_byte = out_byte;
            next_r.tx_start = 1'b1;
            next_r.idx = r.idx + 7'h01;
            next_r.phase = 1'b1;
          end
        end
      end
      default: begin
        next_r.state = ST_WAIT_GAP;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      r <= SLAVE_RST;
    end else begin
      r <= next_r;
    end
  end

  assign tx_en = r.tx_en;
  assign modbus_en = r.modbus_en;
  assign vendor_en = r.vendor_en;
  assign wr_valid = r.wr_valid;
  assign wr_addr = r.wr_addr;
  assign wr_data = r.wr_data;
  assign wr_broadcast = r.bcast;
  assign rd_addr = r.rd_addr;
endmodule
`default_nettype wire

// *** rmb_pkg.sv ***
// Constants, lookup functions and the CRC step for the serial slave front end.
// Assumes a single 250 MHz system clock; no other block state lives here.
package rmb_pkg;
  localparam int unsigned CLK_HZ = 250_000_000;

  localparam logic [4:0] STATION_MIN = 5'h01;
  localparam logic [4:0] STATION_MAX = 5'h1F;
  localparam logic [4:0] STATION_RST = 5'h01;
  localparam logic [7:0] ADDR_BROADCAST = 8'h00;

  localparam logic [1:0] PROTO_NONE = 2'h0;
  localparam logic [1:0] PROTO_VENDOR = 2'h1;
  localparam logic [1:0] PROTO_MODBUS = 2'h2;
  localparam logic [1:0] PROTO_RST = PROTO_VENDOR;

  localparam logic [3:0] BAUD_RST = 4'h6;
  localparam logic [15:0] BITCLK_4800 = 16'(CLK_HZ / 4800);
  localparam logic [15:0] BITCLK_9600 = 16'(CLK_HZ / 9600);
  localparam logic [15:0] BITCLK_19200 = 16'(CLK_HZ / 19200);
  localparam logic [15:0] BITCLK_38400 = 16'(CLK_HZ / 38400);
  localparam logic [15:0] BITCLK_57600 = 16'(CLK_HZ / 57600);
  localparam logic [15:0] BITCLK_76800 = 16'(CLK_HZ / 76800);
  localparam logic [15:0] BITCLK_93750 = 16'(CLK_HZ / 93750);
  localparam logic [15:0] BITCLK_115200 = 16'(CLK_HZ / 115200);
  localparam logic [15:0] BITCLK_187500 = 16'(CLK_HZ / 187500);

  localparam int unsigned CHAR_BITS = 11;
  localparam logic [5:0] GAP_BITS = 6'((CHAR_BITS * 7 + 1) / 2);
  localparam logic [3:0] LAST_BIT = 4'hA;

  localparam logic [7:0] FC_READ = 8'h03;
  localparam logic [7:0] FC_WRITE1 = 8'h06;
  localparam logic [7:0] FC_WRITEN = 8'h10;
  localparam logic [7:0] EXC_FLAG = 8'h80;
  localparam logic [7:0] EXC_ILL_FUNC = 8'h01;
  localparam logic [7:0] EXC_ILL_VALUE = 8'h03;

  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'hA001;

  localparam int unsigned BUF_BYTES = 64;
  localparam logic [15:0] MAX_REGS = 16'h0010;
  localparam logic [6:0] LEN_MIN = 7'h04;
  localparam logic [6:0] LEN_FIXED = 7'h08;
  localparam logic [8:0] LEN_MULTI_BASE = 9'h009;
  localparam logic [6:0] LEN_FULL = 7'h40;
  localparam logic [6:0] ECHO_LEN = 7'h06;
  localparam logic [6:0] EXC_LEN = 7'h03;
  localparam logic [6:0] READ_HDR = 7'h03;
  localparam logic [6:0] WRITE1_DATA = 7'h04;
  localparam logic [6:0] WRITEN_DATA = 7'h07;

  // Clocks per bit for a baud code, zero for an unknown code
  function automatic logic [15:0] bit_clock_count(input logic [3:0] code);
    case (code)
      4'h5: return BITCLK_4800;
      4'h6: return BITCLK_9600;
      4'h7: return BITCLK_19200;
      4'h8: return BITCLK_38400;
      4'h9: return BITCLK_57600;
      4'hA: return BITCLK_76800;
      4'hB: return BITCLK_93750;
      4'hC: return BITCLK_115200;
      4'hD: return BITCLK_187500;
      default: return 16'h0000;
    endcase
  endfunction

  // One byte of the reflected CRC-16
  function automatic logic [15:0] crc16_byte(input logic [15:0] crc, input logic [7:0] data);
    logic [15:0] c;
    c = crc ^ {8'h00, data};
    for (int i = 0; i < 8; i++) begin
      c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction
endpackage

// *** rmb_uart.sv ***
// Byte serialiser for the half-duplex line: 8 data bits, even parity, one stop.
// Assumes bit_clocks is never zero and rx_pin is asynchronous to clk.
`timescale 1ns/1ps
`default_nettype none
module rmb_uart (
  input wire logic clk,
  input wire logic rst,
  input wire logic [15:0] bit_clocks,
  input wire logic rx_pin,
  input wire logic tx_start,
  input wire logic [7:0] tx_byte,
  output logic rx_valid,
  output logic [7:0] rx_byte,
  output logic rx_error,
  output logic line_quiet,
  output logic tx_busy,
  output logic tx_pin
);
  typedef struct packed {
    logic sync1;
    logic sync2;
    logic rx_busy;
    logic [15:0] rx_cnt;
    logic [3:0] rx_bit;
    logic [9:0] rx_shift;
    logic rx_valid;
    logic [7:0] rx_byte;
    logic rx_error;
    logic [15:0] gap_cnt;
    logic [5:0] gap_bits;
    logic line_quiet;
    logic tx_busy;
    logic [15:0] tx_cnt;
    logic [3:0] tx_bit;
    logic [10:0] tx_shift;
  } rmb_uart_s;

  localparam rmb_uart_s UART_RST = '{sync1: 1'b1, sync2: 1'b1, tx_shift: 11'h7FF, default: '0};

  localparam logic [3:0] LAST_BIT_L = rmb_pkg::LAST_BIT;

  rmb_uart_s r;
  rmb_uart_s next_r;

  always_comb begin
    next_r = r;
    next_r.sync1 = rx_pin;
    next_r.sync2 = r.sync1;
    next_r.rx_valid = 1'b0;
    // Receiver, sampling mid-bit
    if (!r.rx_busy) begin
      if (!r.sync2) begin
        next_r.rx_busy = 1'b1;
        next_r.rx_cnt = bit_clocks >> 1;
        next_r.rx_bit = 4'h0;
      end
    end else if (r.rx_cnt != 16'h0000) begin
      next_r.rx_cnt = r.rx_cnt - 16'h0001;
    end else begin
      next_r.rx_cnt = bit_clocks - 16'h0001;
      next_r.rx_bit = r.rx_bit + 4'h1;
      if (r.rx_bit == 4'h0) begin
        next_r.rx_busy = !r.sync2;
      end else begin
        next_r.rx_shift = {r.sync2, r.rx_shift[9:1]};
        if (r.rx_bit == LAST_BIT_L) begin
          next_r.rx_busy = 1'b0;
          next_r.rx_valid = 1'b1;
          next_r.rx_byte = r.rx_shift[8:1];
          next_r.rx_error = !r.sync2 | (^r.rx_shift[9:1]);
        end
      end
    end
    // Bus silence timer, 3.5 characters
    if (r.rx_busy || !r.sync2) begin
      next_r.gap_cnt = 16'h0000;
      next_r.gap_bits = 6'h00;
      next_r.line_quiet = 1'b0;
    end else if (r.gap_bits != rmb_pkg::GAP_BITS) begin
      next_r.gap_cnt = r.gap_cnt + 16'h0001;
      if (r.gap_cnt == bit_clocks - 16'h0001) begin
        next_r.gap_cnt = 16'h0000;
        next_r.gap_bits = r.gap_bits + 6'h01;
        next_r.line_quiet = (r.gap_bits + 6'h01) == rmb_pkg::GAP_BITS;
      end
    end
    // Transmitter
    if (!r.tx_busy) begin
      if (tx_start) begin
        next_r.tx_busy = 1'b1;
        next_r.tx_shift = {1'b1, ^tx_byte, tx_byte, 1'b0};
        next_r.tx_cnt = bit_clocks - 16'h0001;
        next_r.tx_bit = 4'h0;
      end
    end else if (r.tx_cnt != 16'h0000) begin
      next_r.tx_cnt = r.tx_cnt - 16'h0001;
    end else if (r.tx_bit == LAST_BIT_L) begin
      next_r.tx_busy = 1'b0;
      next_r.tx_shift = 11'h7FF;
    end else begin
      next_r.tx_shift = {1'b1, r.tx_shift[10:1]};
      next_r.tx_bit = r.tx_bit + 4'h1;
      next_r.tx_cnt = bit_clocks - 16'h0001;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      r <= UART_RST;
    end else begin
      r <= next_r;
    end
  end

  assign rx_valid = r.rx_valid;
  assign rx_byte = r.rx_byte;
  assign rx_error = r.rx_error;
  assign line_quiet = r.line_quiet;
  assign tx_busy = r.tx_busy;
  assign tx_pin = r.tx_shift[0];
endmodule
`default_nettype wire

// *** rmb_slave_checker.sv ***
// Port checks for the serial slave front end.
// Assumes one clock; the fastest baud gives the shortest legal quiet gap.
`timescale 1ns/1ps
`default_nettype none
module rmb_slave_checker (
  input wire logic clk,
  input wire logic rst,
  input wire logic cfg_load,
  input wire logic [4:0] bus_station_address_setting,
  input wire logic [1:0] link_protocol_selector,
  input wire logic [3:0] link_baud_code,
  input wire logic rx_pin,
  input wire logic [15:0] rd_data,
  input wire logic tx_pin,
  input wire logic tx_en,
  input wire logic modbus_en,
  input wire logic vendor_en,
  input wire logic wr_valid,
  input wire logic [15:0] wr_addr,
  input wire logic [15:0] wr_data,
  input wire logic wr_broadcast,
  input wire logic [15:0] rd_addr
);
  localparam int GAP_MIN = 51987;
  logic [16:0] quiet;
  always_ff @(posedge clk) begin
    if (rst || !rx_pin) quiet <= '0;
    else if (quiet < 17'h1869F) quiet <= quiet + 17'h00001;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence reply_start_s;
    tx_pin ##1 tx_pin ##1 !tx_pin;
  endsequence
  sequence two_writes_s;
    wr_valid ##1 wr_valid;
  endsequence
  reset_idle_a: assert property ($fell(rst) |-> !tx_en && tx_pin && !wr_valid && !modbus_en && vendor_en)
    else $error("reset state wrong");
  cfg_decode_a: assert property (cfg_load |=> modbus_en == ($past(link_protocol_selector) == 2'h2)
    && vendor_en == ($past(link_protocol_selector) == 2'h1)) else $error("selector decode wrong");
  cfg_hold_a: assert property (!cfg_load |=> $stable(modbus_en) && $stable(vendor_en))
    else $error("handler enable moved without load");
  one_handler_a: assert property (!(modbus_en && vendor_en)) else $error("two handlers on");
  reply_mode_a: assert property ($rose(tx_en) |-> modbus_en) else $error("reply while not in RTU mode");
  reply_gap_a: assert property ($rose(tx_en) |-> quiet >= GAP_MIN) else $error("reply without quiet gap");
  reply_start_a: assert property ($rose(tx_en) |-> reply_start_s) else $error("start bit not after enable");
  line_idle_a: assert property (!tx_en |-> tx_pin) else $error("line not idle high");
  write_mode_a: assert property (wr_valid |-> modbus_en && !tx_en) else $error("write outside request");
  write_step_a: assert property (two_writes_s |-> wr_addr == $past(wr_addr) + 16'h0001)
    else $error("write address not consecutive");
  bcast_quiet_a: assert property (wr_valid && wr_broadcast |=> (!tx_en) [*8])
    else $error("reply after broadcast");
endmodule
bind rmb_slave rmb_slave_checker chk (.clk(clk), .rst(rst), .cfg_load(cfg_load),
  .bus_station_address_setting(bus_station_address_setting), .link_protocol_selector(link_protocol_selector),
  .link_baud_code(link_baud_code), .rx_pin(rx_pin), .rd_data(rd_data), .tx_pin(tx_pin), .tx_en(tx_en),
  .modbus_en(modbus_en), .vendor_en(vendor_en), .wr_valid(wr_valid), .wr_addr(wr_addr), .wr_data(wr_data),
  .wr_broadcast(wr_broadcast), .rd_addr(rd_addr));
`default_nettype wire

// *** rmb_plc_model.sv ***
// Bus master model: sends request frames, collects reply characters.
// Assumes 8 data bits, even parity, one stop bit, BIT clocks per bit.
`timescale 1ns/1ps
`default_nettype none
module rmb_plc_model #(parameter int BIT = 1333) (
  input wire logic clk,
  input wire logic tx_pin,
  input wire logic tx_en,
  output logic line
);
  logic [7:0] got[$];
  int bad_char = 0;
  logic [9:0] sh;
  initial line = 1'b1;
  task automatic send_frame(input logic [7:0] f[$], input int gap);
    logic [10:0] ch;
    repeat (40 * BIT) @(posedge clk);
    foreach (f[i]) begin
      ch = {1'b1, ^f[i], f[i], 1'b0};
      for (int b = 0; b < 11; b++) begin
        #1 line = ch[b];
        repeat (BIT) @(posedge clk);
      end
      repeat (gap) @(posedge clk);
    end
  endtask
  // Reply receiver, sampling mid-bit
  initial forever begin
    @(posedge clk);
    if (tx_en === 1'b1 && tx_pin === 1'b0) begin
      repeat (BIT / 2) @(posedge clk);
      for (int b = 0; b < 10; b++) begin
        repeat (BIT) @(posedge clk);
        sh[b] = tx_pin;
      end
      if (sh[8] !== ^sh[7:0] || sh[9] !== 1'b1) bad_char++;
      got.push_back(sh[7:0]);
    end
  end
endmodule
`default_nettype wire

// *** tb.sv ***
// Self-checking bench for the serial slave front end.
// Assumes the master model drives the line and the checker is bound.
`timescale 1ns/1ps
`default_nettype none
module tb;
  typedef logic [7:0] rmb_bytes_t[$];
  localparam int BIT = 1333;
  localparam logic [15:0] KEY = 16'h5AC3;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cfg_load = 1'b0;
  logic [4:0] station = 5'h01;
  logic [1:0] proto = 2'h1;
  logic [3:0] baud = 4'h6;
  logic [15:0] rd_data = 16'h0000;
  logic rx_pin, tx_pin, tx_en, modbus_en, vendor_en, wr_valid, wr_broadcast;
  logic [15:0] wr_addr, wr_data, rd_addr, a, v, w;
  logic [15:0] seed = 16'hE6EF;
  logic [7:0] s;
  logic [32:0] wq[$];
  logic [32:0] wx[$];
  rmb_bytes_t q, none;
  int n_mismatch = 0;
  int comparisons = 0;
  always #2 clk = ~clk;
  always @(rd_addr) rd_data = rd_addr ^ KEY;
  always @(posedge clk) if (wr_valid === 1'b1) wq.push_back({wr_broadcast, wr_addr, wr_data});
  rmb_slave dut (.clk(clk), .rst(rst), .cfg_load(cfg_load), .bus_station_address_setting(station),
    .link_protocol_selector(proto), .link_baud_code(baud), .rx_pin(rx_pin), .rd_data(rd_data),
    .tx_pin(tx_pin), .tx_en(tx_en), .modbus_en(modbus_en), .vendor_en(vendor_en), .wr_valid(wr_valid),
    .wr_addr(wr_addr), .wr_data(wr_data), .wr_broadcast(wr_broadcast), .rd_addr(rd_addr));
  rmb_plc_model #(.BIT(BIT)) plc (.clk(clk), .tx_pin(tx_pin), .tx_en(tx_en), .line(rx_pin));
  function automatic logic [15:0] rnd();
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    return seed;
  endfunction
  function automatic rmb_bytes_t crc_add(rmb_bytes_t f);
    logic [15:0] c;
    c = 16'hFFFF;
    foreach (f[i]) begin
      c = c ^ {8'h00, f[i]};
      for (int b = 0; b < 8; b++) c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
    end
    f.push_back(c[7:0]);
    f.push_back(c[15:8]);
    return f;
  endfunction
  task automatic check(input string what, input logic [32:0] seen, input logic [32:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wrap_up();
    if (n_mismatch == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic load(input logic [1:0] p, input logic [4:0] st, input logic [3:0] b);
    @(posedge clk);
    #1 cfg_load = 1'b1;
    proto = p;
    station = st;
    baud = b;
    @(posedge clk);
    #1 cfg_load = 1'b0;
    @(posedge clk);
    #1;
  endtask
  task automatic transact(input rmb_bytes_t req, input rmb_bytes_t rsp, input int gap);
    int n;
    plc.got.delete();
    wq.delete();
    plc.send_frame(req, gap);
    n = 0;
    while (plc.got.size() < rsp.size() && n < 400000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 400000) begin
      n_mismatch++;
      wrap_up();
    end
    repeat (61 * BIT) @(posedge clk);
    check("reply length", plc.got.size(), rsp.size());
    foreach (rsp[i]) if (i < plc.got.size()) check("reply byte", plc.got[i], rsp[i]);
    check("write count", wq.size(), wx.size());
    foreach (wx[i]) if (i < wq.size()) check("write", wq[i], wx[i]);
    check("char framing", plc.bad_char, 0);
    wx.delete();
  endtask
  initial begin
    repeat (5) @(posedge clk);
    #1 rst = 1'b0;
    @(posedge clk);
    #1;
    check("vendor_en", vendor_en, 1'b1);
    check("modbus_en", modbus_en, 1'b0);
    check("tx idle", {tx_en, tx_pin}, 2'b01);
    for (int p = 0; p < 4; p++) begin
      load(p[1:0], 5'h01, 4'hD);
      check("modbus_en", modbus_en, p == 2);
      check("vendor_en", vendor_en, p == 1);
    end
    s = 8'(rnd() % 31 + 1);
    load(2'h2, s[4:0], 4'hD);
    load(2'h2, 5'h00, 4'h4);
    a = rnd();
    v = rnd();
    wx.push_back({1'b0, a, v});
    q = crc_add({s, 8'h06, a[15:8], a[7:0], v[15:8], v[7:0]});
    transact(q, q, BIT);
    a = rnd();
    v = a ^ KEY;
    w = (a + 16'h0001) ^ KEY;
    q = crc_add({s, 8'h03, a[15:8], a[7:0], 8'h00, 8'h02});
    transact(q, crc_add({s, 8'h03, 8'h04, v[15:8], v[7:0], w[15:8], w[7:0]}), 0);
    a = rnd();
    v = rnd();
    w = rnd();
    wx.push_back({1'b1, a, v});
    wx.push_back({1'b1, a + 16'h0001, w});
    q = crc_add({8'h00, 8'h10, a[15:8], a[7:0], 8'h00, 8'h02, 8'h04, v[15:8], v[7:0], w[15:8], w[7:0]});
    transact(q, none, 0);
    q = crc_add({s, 8'h04, 8'h00, 8'h00, 8'h00, 8'h01});
    transact(q, crc_add({s, 8'h84, 8'h01}), 0);
    q = crc_add({s, 8'h03, 8'h00, 8'h00, 8'h00, 8'h11});
    transact(q, crc_add({s, 8'h83, 8'h03}), 0);
    a = rnd();
    v = rnd();
    wx.push_back({1'b0, a, v});
    q = crc_add({s, 8'h10, a[15:8], a[7:0], 8'h00, 8'h01, 8'h02, v[15:8], v[7:0]});
    transact(q, crc_add({s, 8'h10, a[15:8], a[7:0], 8'h00, 8'h01}), 0);
    q = crc_add({8'(s % 8'd31 + 8'd1), 8'h06, 8'h00, 8'h01, 8'h00, 8'h02});
    transact(q, none, 0);
    q = crc_add({s, 8'h06, 8'h00, 8'h01, 8'h00, 8'h02});
    q[7] = ~q[7];
    transact(q, none, 0);
    q = {8'h3A, 8'h30, 8'h31, 8'h30, 8'h36, 8'h0D, 8'h0A};
    transact(q, none, 0);
    wrap_up();
  end
endmodule
`default_nettype wire
